/* File: rtl/asqp_pkg.sv */
/*
 * Constants of the cell queue packer: register offsets, field positions,
 * reset values and cell geometry.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package asqp_pkg;
   // Register byte offsets
   localparam logic [7:0] PCR_OFF = 8'h00;   // port_control_register
   localparam logic [7:0] CDR_OFF = 8'h14;   // clock_detect_register
   localparam logic [7:0] EER_OFF = 8'h18;   // error_enable_register
   localparam logic [7:0] EPR_OFF = 8'h1C;   // error_pending_register
   localparam logic [7:0] RXQ_OFF = 8'h40;   // receive queue data port
   localparam logic [7:0] TXQ_OFF = 8'h44;   // transmit queue data port

   // port_control_register fields
   localparam int PCR_ORDER_BIT  = 31;
   localparam int PCR_TX_UDC_LSB = 18;
   localparam int PCR_TX_EN_BIT  = 16;
   localparam int PCR_RX_UDC_LSB = 2;
   localparam int PCR_RX_EN_BIT  = 0;

   // clock_detect_register fields, section 0 receive, 1 transmit
   localparam int CDR_RX_LSB = 0;
   localparam int CDR_TX_LSB = 8;
   localparam logic [7:0] CDR_RESET = 8'h20;

   // Pending and enable bit positions
   localparam int EP_FAIL_LSB = 0;   // rx_clock_failed_flag, tx_clock_failed_flag
   localparam int EP_PRES_LSB = 2;   // rx_clock_present_flag, tx_clock_present_flag
   localparam int EP_RX_STALL = 4;   // rx_queue_stall_flag
   localparam int EP_TX_STALL = 5;   // tx_queue_stall_flag

   // Cell geometry
   localparam logic [3:0] MAX_UDB    = 4'hB;   // largest user byte count
   localparam logic [6:0] LAST_CORE  = 7'h34;  // header 1..4, check byte, 48 payload
   localparam logic [4:0] CORE_WORDS = 5'h0D;  // header word plus 12 payload words
   localparam logic [5:0] Q_DEPTH    = 6'h20;  // words per queue
endpackage : asqp_pkg

/* File: rtl/asqp_map_if.sv */
/*
 * Carrier between the queue top and its lane mapper.
 * Assumes the mapper is purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
interface asqp_map_if;
   logic [3:0] user_count;
   logic       big_endian;
   logic [6:0] link_index;
   logic [1:0] lane;
   logic       word_done;
   logic       cell_done;
   logic [4:0] cell_words;
   modport user   (output user_count, big_endian, link_index, input lane, word_done, cell_done, cell_words);
   modport mapper (input user_count, big_endian, link_index, output lane, word_done, cell_done, cell_words);
endinterface : asqp_map_if
`default_nettype wire

/* File: rtl/asqp_lane_map.sv */
/*
 * Maps a link byte index of a cell to its queue word lane.
 * Assumes the caller keeps the index below the cell length.
 */
`timescale 1ns/1ps
`default_nettype none
module asqp_lane_map (
   asqp_map_if.mapper m
);
   logic [3:0] n;
   logic [1:0] pad;
   logic [6:0] k;
   logic [1:0] pos;

   // Dummy bytes lead the stream so payload lands word aligned
   always_comb begin
      n   = (m.user_count > asqp_pkg::MAX_UDB) ? asqp_pkg::MAX_UDB : m.user_count;
      pad = ~n[1:0];
      k   = m.link_index + {5'h00, pad};
      pos = k[1:0];
      m.lane       = m.big_endian ? ~pos : pos;
      m.word_done  = (pos == 2'h3);
      m.cell_done  = (m.link_index == ({3'h0, n} + asqp_pkg::LAST_CORE));
      m.cell_words = 5'(({1'b0, n} + 5'h04) >> 2) + asqp_pkg::CORE_WORDS;
   end
endmodule : asqp_lane_map
`default_nettype wire

/* File: rtl/asqp_top.sv */
/*
 * Cell queues of a byte-wide cell slave: word packing, clock loss
 * detection, queue stalls and the error pending logic.
 * Assumes a classic Wishbone master on clk_in and link clocks from the
 * far master, sampled here through two flip-flops.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Registers and queues run on peripheral clock
// - Programmable per-section clock loss counts
// - Lost link clock resets its section
// - Clock loss sets matching failed flag
// - Interrupt when pending flag and enable set
// - Detected clock sets present flag after reset or loss
// - Full transmit queue holds writes, never overwrites
// - Transmit stall flag while write held off
// - Empty receive queue holds reads
// - Receive stall flag until held read completes
// - Byte order select picks lane order
// - Dummy bytes never cross the link
// - Little endian, no user bytes layout
// - Big endian, no user bytes layout
// - Big endian, one user byte layout
// - Little endian, seven user bytes layout
// - Little endian, eleven user bytes layout
// - Big endian, eleven user bytes layout
// - Disabling section idles it, keeps registers
module asqp_top (
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   output logic             error_interrupt_out,
   input  wire logic        tx_link_clock_in,
   input  wire logic        tx_link_enable_n_in,
   output logic      [7:0]  tx_link_data_out,
   output logic             tx_link_soc_out,
   output logic             tx_link_valid_out,
   input  wire logic        rx_link_clock_in,
   input  wire logic        rx_link_enable_n_in,
   input  wire logic        rx_link_soc_in,
   input  wire logic [7:0]  rx_link_data_in,
   output logic             tx_queue_ready_event_out,
   output logic             rx_queue_ready_event_out
);
   // Pin vector positions
   localparam int P_RX_CLK = 12;
   localparam int P_RX_EN  = 11;
   localparam int P_RX_SOC = 10;
   localparam int P_RX_DAT = 2;
   localparam int P_TX_CLK = 1;
   localparam int P_TX_EN  = 0;

   typedef struct packed {
      logic                ack;
      logic [31:0]         rdata;
      logic                irq;
      logic                byte_order;
      logic [1:0]          sec_en;       // 0 receive, 1 transmit
      logic [1:0][3:0]     udc;
      logic [1:0][7:0]     lim;
      logic [5:0]          ena;
      logic [5:0]          pend;
      logic [12:0]         meta;
      logic [12:0]         sync;
      logic [1:0]          clk_prev;
      logic [1:0]          clk_ok;
      logic [1:0][7:0]     idle;
      logic [31:0][31:0]   txq;
      logic [31:0][31:0]   rxq;
      logic [5:0]          tx_wp;
      logic [5:0]          tx_rp;
      logic [5:0]          rx_wp;
      logic [5:0]          rx_rp;
      logic                tx_busy;
      logic                rx_busy;
      logic [6:0]          tx_j;
      logic [6:0]          rx_j;
      logic [31:0]         rx_asm;
      logic [7:0]          tx_data;
      logic                tx_soc;
      logic                tx_valid;
      logic                tx_ev;
      logic                rx_ev;
   } asqp_state_t;

   asqp_state_t st_reg;
   asqp_state_t st_next;
   logic [1:0]  fail;
   logic [1:0]  clk_now;
   logic [5:0]  tx_cnt;
   logic [5:0]  rx_cnt;
   logic [31:0] pcr_val;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic        req;
   logic [31:0] head;

   asqp_map_if tx_map ();
   asqp_map_if rx_map ();

   asqp_lane_map u_tx_map (
      .m (tx_map)
   );
   asqp_lane_map u_rx_map (
      .m (rx_map)
   );

   // Mapper inputs; receive restarts its index on a start-of-cell byte
   assign tx_map.user_count = st_reg.udc[1];
   assign tx_map.big_endian = st_reg.byte_order;
   assign tx_map.link_index = st_reg.tx_j;
   assign rx_map.user_count = st_reg.udc[0];
   assign rx_map.big_endian = st_reg.byte_order;
   assign rx_map.link_index = st_reg.sync[P_RX_SOC] ? 7'h00 : st_reg.rx_j;

   // Queue fill levels and current register images
   assign tx_cnt  = st_reg.tx_wp - st_reg.tx_rp;
   assign rx_cnt  = st_reg.rx_wp - st_reg.rx_rp;
   assign head    = st_reg.txq[st_reg.tx_rp[4:0]];
   assign clk_now = {st_reg.sync[P_TX_CLK], st_reg.sync[P_RX_CLK]};
   assign req     = wb_cyc_in & wb_stb_in & ~st_reg.ack;
   assign wmask   = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

   always_comb begin
      pcr_val = 32'h0000_0000;
      pcr_val[asqp_pkg::PCR_ORDER_BIT] = st_reg.byte_order;
      pcr_val[asqp_pkg::PCR_TX_UDC_LSB +: 4] = st_reg.udc[1];
      pcr_val[asqp_pkg::PCR_TX_EN_BIT] = st_reg.sec_en[1];
      pcr_val[asqp_pkg::PCR_RX_UDC_LSB +: 4] = st_reg.udc[0];
      pcr_val[asqp_pkg::PCR_RX_EN_BIT] = st_reg.sec_en[0];
   end

   // Next state: bus slave, clock watch, link engines, section resets
   always_comb begin
      st_next = st_reg;
      fail    = 2'h0;
      wval    = 32'h0000_0000;
      st_next.ack  = 1'b0;
      st_next.meta = {rx_link_clock_in, rx_link_enable_n_in, rx_link_soc_in, rx_link_data_in,
                      tx_link_clock_in, tx_link_enable_n_in};
      st_next.sync = st_reg.meta;
      st_next.pend[asqp_pkg::EP_TX_STALL] = 1'b0;
      st_next.pend[asqp_pkg::EP_RX_STALL] = 1'b0;
      st_next.irq = |(st_reg.pend & st_reg.ena);
      // Bus slave; unmapped offsets answer with zero
      if (req) begin
         unique case (wb_adr_in)
            asqp_pkg::PCR_OFF: begin
               st_next.ack   = 1'b1;
               st_next.rdata = pcr_val;
               wval = (pcr_val & ~wmask) | (wb_dat_in & wmask);
               if (wb_we_in) begin
                  st_next.byte_order = wval[asqp_pkg::PCR_ORDER_BIT];
                  st_next.udc[1]     = wval[asqp_pkg::PCR_TX_UDC_LSB +: 4];
                  st_next.sec_en[1]  = wval[asqp_pkg::PCR_TX_EN_BIT];
                  st_next.udc[0]     = wval[asqp_pkg::PCR_RX_UDC_LSB +: 4];
                  st_next.sec_en[0]  = wval[asqp_pkg::PCR_RX_EN_BIT];
               end
            end
            asqp_pkg::CDR_OFF: begin
               st_next.ack   = 1'b1;
               st_next.rdata = {16'h0000, st_reg.lim[1], st_reg.lim[0]};
               wval = (st_next.rdata & ~wmask) | (wb_dat_in & wmask);
               if (wb_we_in) begin
                  st_next.lim[0] = wval[asqp_pkg::CDR_RX_LSB +: 8];
                  st_next.lim[1] = wval[asqp_pkg::CDR_TX_LSB +: 8];
               end
            end
            asqp_pkg::EER_OFF: begin
               st_next.ack   = 1'b1;
               st_next.rdata = {26'h0000000, st_reg.ena};
               if (wb_we_in && wb_sel_in[0]) begin
                  st_next.ena = wb_dat_in[5:0];
               end
            end
            asqp_pkg::EPR_OFF: begin
               st_next.ack   = 1'b1;
               st_next.rdata = {26'h0000000, st_reg.pend};
               // Write one clears the clock flags; stall flags are read only
               if (wb_we_in && wb_sel_in[0]) begin
                  st_next.pend[3:0] = st_reg.pend[3:0] & ~wb_dat_in[3:0];
               end
            end
            asqp_pkg::TXQ_OFF: begin
               st_next.rdata = 32'h0000_0000;
               if (!wb_we_in) begin
                  st_next.ack = 1'b1;
               end else if (tx_cnt == asqp_pkg::Q_DEPTH) begin
                  st_next.pend[asqp_pkg::EP_TX_STALL] = 1'b1;
               end else begin
                  st_next.ack = 1'b1;
                  st_next.txq[st_reg.tx_wp[4:0]] = wb_dat_in;
                  st_next.tx_wp = st_reg.tx_wp + 6'h01;
               end
            end
            asqp_pkg::RXQ_OFF: begin
               if (wb_we_in) begin
                  st_next.ack = 1'b1;
               end else if (rx_cnt == 6'h00) begin
                  st_next.pend[asqp_pkg::EP_RX_STALL] = 1'b1;
               end else begin
                  st_next.ack   = 1'b1;
                  st_next.rdata = st_reg.rxq[st_reg.rx_rp[4:0]];
                  st_next.rx_rp = st_reg.rx_rp + 6'h01;
               end
            end
            default: begin
               st_next.ack   = 1'b1;
               st_next.rdata = 32'h0000_0000;
            end
         endcase
      end
      // Clock watch per section; a set beats a same-cycle clear
      for (int i = 0; i < 2; i++) begin
         st_next.clk_prev[i] = clk_now[i];
         if (clk_now[i] != st_reg.clk_prev[i]) begin
            st_next.idle[i] = 8'h00;
            if (!st_reg.clk_ok[i]) begin
               st_next.clk_ok[i] = 1'b1;
               st_next.pend[asqp_pkg::EP_PRES_LSB + i] = 1'b1;
            end
         end else begin
            if (st_reg.idle[i] != 8'hFF) begin
               st_next.idle[i] = st_reg.idle[i] + 8'h01;
            end
            if (st_reg.clk_ok[i] && st_reg.lim[i] != 8'h00 && st_reg.idle[i] >= st_reg.lim[i]) begin
               fail[i] = 1'b1;
               st_next.clk_ok[i] = 1'b0;
               st_next.pend[asqp_pkg::EP_FAIL_LSB + i] = 1'b1;
               st_next.sec_en[i] = 1'b0;
               st_next.udc[i]    = 4'h0;
            end
         end
      end
      // Transmit engine: one byte per link clock rise while asked for
      if (clk_now[1] && !st_reg.clk_prev[1] && st_reg.sec_en[1]) begin
         st_next.tx_valid = 1'b0;
         if (!st_reg.sync[P_TX_EN] && (st_reg.tx_busy || {1'b0, tx_cnt} >= {2'b00, tx_map.cell_words})) begin
            st_next.tx_data  = head[{tx_map.lane, 3'h0} +: 8];
            st_next.tx_soc   = (st_reg.tx_j == 7'h00);
            st_next.tx_valid = 1'b1;
            st_next.tx_busy  = ~tx_map.cell_done;
            st_next.tx_j     = tx_map.cell_done ? 7'h00 : st_reg.tx_j + 7'h01;
            if (tx_map.word_done) begin
               st_next.tx_rp = st_reg.tx_rp + 6'h01;
            end
         end
      end
      // Receive engine: bytes land in their lane, pads stay zero
      if (clk_now[0] && !st_reg.clk_prev[0] && st_reg.sec_en[0] && !st_reg.sync[P_RX_EN] &&
          (st_reg.rx_busy || st_reg.sync[P_RX_SOC])) begin
         st_next.rx_asm = (rx_map.link_index == 7'h00) ? 32'h0000_0000 : st_reg.rx_asm;
         st_next.rx_asm[{rx_map.lane, 3'h0} +: 8] = st_reg.sync[P_RX_DAT +: 8];
         st_next.rx_busy = ~rx_map.cell_done;
         st_next.rx_j    = rx_map.cell_done ? 7'h00 : rx_map.link_index + 7'h01;
         // Overflow drops the word rather than overwrite queued data
         if (rx_map.word_done && rx_cnt != asqp_pkg::Q_DEPTH) begin
            st_next.rxq[st_reg.rx_wp[4:0]] = st_next.rx_asm;
            st_next.rx_wp = st_reg.rx_wp + 6'h01;
         end
      end
      // Section idle on clock loss or while disabled; clock loss also clears its enable and user count
      if (fail[1] || !st_reg.sec_en[1]) begin
         st_next.tx_wp    = 6'h00;
         st_next.tx_rp    = 6'h00;
         st_next.tx_busy  = 1'b0;
         st_next.tx_j     = 7'h00;
         st_next.tx_valid = 1'b0;
         st_next.tx_soc   = 1'b0;
      end
      if (fail[0] || !st_reg.sec_en[0]) begin
         st_next.rx_wp   = 6'h00;
         st_next.rx_rp   = 6'h00;
         st_next.rx_busy = 1'b0;
         st_next.rx_j    = 7'h00;
      end
      // Ready events tell the servicing agent a whole cell fits or waits
      st_next.tx_ev = st_reg.sec_en[1] && ({1'b0, asqp_pkg::Q_DEPTH - tx_cnt} >= {2'b00, tx_map.cell_words});
      st_next.rx_ev = st_reg.sec_en[0] && ({1'b0, rx_cnt} >= {2'b00, rx_map.cell_words});
   end

   // Everything on the peripheral clock, synchronous reset
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         st_reg     <= '0;
         st_reg.lim <= {asqp_pkg::CDR_RESET, asqp_pkg::CDR_RESET};
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_dat_out               = st_reg.rdata;
   assign wb_ack_out               = st_reg.ack;
   assign error_interrupt_out      = st_reg.irq;
   assign tx_link_data_out         = st_reg.tx_data;
   assign tx_link_soc_out          = st_reg.tx_soc;
   assign tx_link_valid_out        = st_reg.tx_valid;
   assign tx_queue_ready_event_out = st_reg.tx_ev;
   assign rx_queue_ready_event_out = st_reg.rx_ev;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   tx_full_hold_a: assert property (req && wb_we_in && wb_adr_in == asqp_pkg::TXQ_OFF && tx_cnt[5]
      |=> !st_reg.ack)
      else $error("write acked into a full transmit queue");
   tx_stall_flag_a: assert property (req && wb_we_in && wb_adr_in == asqp_pkg::TXQ_OFF && tx_cnt[5]
      |=> st_reg.pend[5])
      else $error("transmit stall flag missing");
   rx_empty_hold_a: assert property (req && !wb_we_in && wb_adr_in == asqp_pkg::RXQ_OFF && rx_cnt == 6'h00
      |=> !st_reg.ack)
      else $error("read acked from an empty receive queue");
   rx_stall_clear_a: assert property (st_reg.pend[4] && req && rx_cnt != 6'h00
      |=> st_reg.ack && !st_reg.pend[4])
      else $error("receive stall flag held past completion");
   irq_gate_a: assert property (##1 error_interrupt_out == $past(|(st_reg.pend & st_reg.ena)))
      else $error("interrupt does not follow pending and enable");
   clk_fail_a: assert property (fail[1] |=> st_reg.pend[1] && !st_reg.sec_en[1] ##1 tx_cnt == 6'h00)
      else $error("transmit clock loss not handled");
   clk_present_a: assert property (clk_now[0] != st_reg.clk_prev[0] && !st_reg.clk_ok[0] |=> st_reg.pend[2])
      else $error("receive clock present flag not set");
   sec_idle_a: assert property (!st_reg.sec_en[0] && !fail[0] && !req
      |=> rx_cnt == 6'h00 && !st_reg.rx_busy && $stable(st_reg.lim))
      else $error("disabled receive section not idle");
   le_zero_a: assert property (!tx_map.big_endian && tx_map.user_count == 4'h0 && tx_map.link_index == 7'h00
      |-> tx_map.lane == 2'h3 && tx_map.cell_words == 5'h0E)
      else $error("little endian header lane wrong");
   be_one_a: assert property (tx_map.big_endian && tx_map.user_count == 4'h1 && tx_map.link_index == 7'h01
      |-> tx_map.lane == 2'h0 && tx_map.word_done)
      else $error("big endian user byte layout wrong");
   be_eleven_a: assert property (tx_map.big_endian && tx_map.user_count == 4'hB && tx_map.link_index == 7'h0B
      |-> tx_map.lane == 2'h0 && tx_map.cell_words == 5'h10)
      else $error("big endian eleven user bytes layout wrong");
endmodule : asqp_top
`default_nettype wire

/* File: tb/asqp_master_model.sv */
/* Far-side cell master: free-running link clocks, cell send and collect.
   Assumes the bench calls its tasks and may stop a clock as a fault. */
`timescale 1ns/1ps
`default_nettype none
module asqp_master_model (
   input  wire logic       tx_soc_in,
   input  wire logic       tx_valid_in,
   input  wire logic [7:0] tx_data_in,
   output logic            tx_clk_out,
   output logic            tx_en_n_out,
   output logic            rx_clk_out,
   output logic            rx_en_n_out,
   output logic            rx_soc_out,
   output logic [7:0]      rx_data_out
);
   logic       tx_run = 1'h1;
   logic       rx_run = 1'h1;
   logic [7:0] got_q[$];
   logic       soc_q[$];
   // Clocks low, enables idle high; both links toggle every 100 ns while running
   initial begin
      {tx_clk_out, rx_clk_out, tx_en_n_out, rx_en_n_out, rx_soc_out, rx_data_out} = {4'h3, 9'h0};
      forever begin
         #100;
         if (tx_run) tx_clk_out = ~tx_clk_out;
         if (rx_run) rx_clk_out = ~rx_clk_out;
      end
   end
   // Bytes change on the falling edge, so they are stable at each rise
   task automatic send_cell(input logic [7:0] b[$]);
      foreach (b[j]) begin
         @(negedge rx_clk_out);
         rx_en_n_out <= 1'h0;
         rx_soc_out  <= (j == 0);
         rx_data_out <= b[j];
      end
      @(negedge rx_clk_out);
      rx_en_n_out <= 1'h1;            // Stops only after a whole cell
      rx_soc_out  <= 1'h0;
      rx_data_out <= ~rx_data_out;    // Released bus shows no stale byte
   endtask : send_cell
   // A byte launched at one rise is read at the next
   task automatic recv_cell(input int n);
      got_q.delete();
      soc_q.delete();
      @(negedge tx_clk_out);
      tx_en_n_out <= 1'h0;
      for (int i = 0; i < n + 8 && got_q.size() < n; i++) begin
         @(posedge tx_clk_out);
         if (tx_valid_in === 1'h1) begin
            got_q.push_back(tx_data_in);
            soc_q.push_back(tx_soc_in);
         end
      end
      @(negedge tx_clk_out);
      tx_en_n_out <= 1'h1;            // Graceful stop at cell end
   endtask : recv_cell
endmodule : asqp_master_model
`default_nettype wire

/* File: tb/tb_asqp_top.sv */
/* Self-checking bench of the cell queue top: registers, packing, stalls,
   clock loss. Assumes asqp_pkg, asqp_top and the master model. */
`timescale 1ns/1ps
`default_nettype none
module tb_asqp_top;
   logic        clk_in    = 1'h0;
   logic        srst_in   = 1'h1;
   logic        cyc       = 1'h0;
   logic        we        = 1'h0;
   logic [7:0]  adr       = 8'h00;
   logic [31:0] wdat      = 32'h0;
   logic [31:0] rdat;
   logic [31:0] dat_o;
   logic        ack, irq, txc, txe, rxc, rxe, rxs, txs, txv, txr, rxr;
   logic [7:0]  txd, rxd;
   int          err_count = 0;
   int          checks    = 0;
   int          mcnt[6]   = '{0, 0, 1, 7, 11, 11};   // Legal counts only
   logic        mbe[6]    = '{0, 1, 1, 0, 0, 1};
   asqp_top DUT (
      .clk_in, .srst_in, .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(dat_o), .wb_ack_out(ack),
      .error_interrupt_out(irq), .tx_link_clock_in(txc), .tx_link_enable_n_in(txe),
      .tx_link_data_out(txd), .tx_link_soc_out(txs), .tx_link_valid_out(txv),
      .rx_link_clock_in(rxc), .rx_link_enable_n_in(rxe), .rx_link_soc_in(rxs),
      .rx_link_data_in(rxd), .tx_queue_ready_event_out(txr), .rx_queue_ready_event_out(rxr));
   asqp_master_model fm (
      .tx_soc_in(txs), .tx_valid_in(txv), .tx_data_in(txd), .tx_clk_out(txc), .tx_en_n_out(txe),
      .rx_clk_out(rxc), .rx_en_n_out(rxe), .rx_soc_out(rxs), .rx_data_out(rxd));
   // 40 MHz peripheral clock
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic give_verdict();
      if (err_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   // Classic cycle held until ack is seen at an edge; no fixed latency assumed
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      cyc  <= 1'h1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge clk_in); while (ack !== 1'h1);
      rdat = dat_o;
      cyc <= 1'h0;
   endtask : bus
   task automatic wait_bus();
      for (int i = 0; i < 900 && cyc !== 1'h0; i++) @(posedge clk_in);
      check(32'(cyc), 32'h0);
   endtask : wait_bus
   function automatic logic [7:0] bval(input int j, input int s);
      bval = 8'(j * 5 + s * 16 + 1);
   endfunction : bval
   // Queue word w of a cell; dummies are EE, or with m set a lane mask
   function automatic logic [31:0] qword(input int c, input logic be, input int w, input int s, input logic m);
      int j;
      for (int l = 0; l < 4; l++) begin
         j = 4 * w + (be ? 3 - l : l) - (3 - c % 4);
         qword[8*l +: 8] = (j < 0) ? (m ? 8'h00 : 8'hEE) : (m ? 8'hFF : bval(j, s));
      end
   endfunction : qword
   function automatic logic [31:0] pcr(input int tc, input int rc, input logic be, input logic te, input logic re);
      pcr = {be, 9'h0, 4'(tc), 1'h0, te, 10'h0, 4'(rc), 1'h0, re};
   endfunction : pcr
   task automatic check_cell(input int n, input int s);
      check(32'(fm.got_q.size()), 32'(n));
      check(32'(fm.soc_q[0]), 32'h1);
      for (int j = 0; j < n; j++)
         check(32'(fm.got_q[j]), 32'(bval(j, s)));
   endtask : check_cell
   task automatic check_reset();
      repeat (20) @(posedge clk_in);
      bus(1'h0, asqp_pkg::PCR_OFF, 32'h0);
      check(rdat, 32'h0);
      bus(1'h0, asqp_pkg::CDR_OFF, 32'h0);
      check(rdat, {16'h0, asqp_pkg::CDR_RESET, asqp_pkg::CDR_RESET});
      bus(1'h0, asqp_pkg::EPR_OFF, 32'h0);
      check(rdat, 32'hC);
      bus(1'h1, asqp_pkg::EPR_OFF, 32'hF);
      bus(1'h0, 8'h30, 32'h0);   // Unmapped place must still answer
      check(32'(irq), 32'h0);
   endtask : check_reset
   // One cell each way in one lane layout, then both sections disabled
   task automatic run_mode(input int c, input logic be);
      logic [7:0]  b[$];
      logic [31:0] mk;
      int          nw;
      nw = (c + 56 - c % 4) / 4;
      bus(1'h1, asqp_pkg::PCR_OFF, pcr(c, c, be, 1'h1, 1'h1));
      repeat (3) @(posedge clk_in);
      check(32'(txr), 32'h1); // Writes only under the ready event
      for (int w = 0; w < nw; w++) bus(1'h1, asqp_pkg::TXQ_OFF, qword(c, be, w, c, 1'h0));
      fm.recv_cell(c + 53);
      check_cell(c + 53, c);
      for (int j = 0; j < c + 53; j++) b.push_back(bval(j, c + 1));
      fm.send_cell(b);
      for (int i = 0; i < 60 && rxr !== 1'h1; i++) @(posedge clk_in);
      check(32'(rxr), 32'h1);
      for (int w = 0; w < nw; w++) begin
         bus(1'h0, asqp_pkg::RXQ_OFF, 32'h0);
         mk = qword(c, be, w, c + 1, 1'h1);
         check(rdat & mk, qword(c, be, w, c + 1, 1'h0) & mk);
      end
      bus(1'h1, asqp_pkg::PCR_OFF, pcr(c, c, be, 1'h0, 1'h0));
      bus(1'h0, asqp_pkg::PCR_OFF, 32'h0);
      check(rdat, pcr(c, c, be, 1'h0, 1'h0));
      check(32'({txr, rxr}), 32'h0);
   endtask : run_mode
   // Full transmit queue: the 33rd write waits while the master drains a cell
   task automatic tx_stall();
      bus(1'h1, asqp_pkg::EER_OFF, 32'h20);
      bus(1'h1, asqp_pkg::PCR_OFF, pcr(0, 0, 1'h0, 1'h1, 1'h0));
      for (int w = 0; w < 32; w++) bus(1'h1, asqp_pkg::TXQ_OFF, qword(0, 1'h0, w % 14, w / 14, 1'h0));
      fork
         bus(1'h1, asqp_pkg::TXQ_OFF, 32'h0);
      join_none
      repeat (10) @(posedge clk_in);
      check(32'({irq, txr, ack}), 32'h4);
      fm.recv_cell(53);
      check_cell(53, 0);
      wait_bus();
      bus(1'h0, asqp_pkg::EPR_OFF, 32'h0);
      check(32'({rdat[5], irq}), 32'h0);
      bus(1'h1, asqp_pkg::PCR_OFF, 32'h0);
   endtask : tx_stall
   // Read of an empty receive queue completes once the first word lands
   task automatic rx_stall();
      logic [7:0]  b[$];
      logic [31:0] mk;
      bus(1'h1, asqp_pkg::EER_OFF, 32'h10);
      bus(1'h1, asqp_pkg::PCR_OFF, pcr(0, 0, 1'h0, 1'h0, 1'h1));
      fork
         bus(1'h0, asqp_pkg::RXQ_OFF, 32'h0);
      join_none
      repeat (10) @(posedge clk_in);
      check(32'({irq, rxr}), 32'h2);
      for (int j = 0; j < 53; j++) b.push_back(bval(j, 9));
      fm.send_cell(b);
      wait_bus();
      mk = qword(0, 1'h0, 0, 9, 1'h1);
      check(rdat & mk, qword(0, 1'h0, 0, 9, 1'h0) & mk);
      check(32'(irq), 32'h0);
      bus(1'h1, asqp_pkg::PCR_OFF, 32'h0);
   endtask : rx_stall
   // Both clocks stop; only transmit detection is armed, so only it trips
   task automatic clock_loss();
      bus(1'h1, asqp_pkg::CDR_OFF, 32'h1000);
      bus(1'h1, asqp_pkg::EER_OFF, 32'h0);
      bus(1'h1, asqp_pkg::PCR_OFF, pcr(5, 5, 1'h0, 1'h1, 1'h1));
      fm.tx_run = 1'h0;
      fm.rx_run = 1'h0;
      repeat (40) @(posedge clk_in);
      bus(1'h0, asqp_pkg::EPR_OFF, 32'h0);
      check(rdat, 32'h2);
      bus(1'h0, asqp_pkg::PCR_OFF, 32'h0);
      check(rdat, pcr(0, 5, 1'h0, 1'h0, 1'h1));
      bus(1'h1, asqp_pkg::EER_OFF, 32'h2);
      @(posedge clk_in);   // Interrupt lags the enable write by one edge
      check(32'(irq), 32'h1);
      bus(1'h1, asqp_pkg::EER_OFF, 32'h0);
      @(posedge clk_in);
      check(32'(irq), 32'h0);
      fm.tx_run = 1'h1;
      fm.rx_run = 1'h1;
      repeat (40) @(posedge clk_in);
      bus(1'h1, asqp_pkg::EER_OFF, 32'h8);
      @(posedge clk_in);
      check(32'(irq), 32'h1);
      bus(1'h1, asqp_pkg::CDR_OFF, 32'h2020);
   endtask : clock_loss
   // Main sequence after six reset cycles
   initial begin
      repeat (6) @(posedge clk_in);
      srst_in <= 1'h0;
      check_reset();
      for (int i = 0; i < 6; i++) run_mode(mcnt[i], mbe[i]);
      tx_stall();
      rx_stall();
      clock_loss();
      give_verdict();
   end
   // Hang guard, several times the expected run length
   initial begin
      #2000000;
      err_count++;
      give_verdict();
   end
endmodule : tb_asqp_top
`default_nettype wire
